// ---- verilog/bif_defines.vh ----
// constants for the baseband interrupt flag block
// How it works
// - twelve events and four levels gathered into 16-bit status register
// - reset status value has only bit 7 set
// - enabled flags drive open-drain active-low pin
// - bit 15 special command done, read clears
// - bit 14 aux converter done, read clears
// - bit 13 second rx message end, burst only
// - bit 12 first rx message end, burst only
// - bit 11 transmit queue fault, read clears
// - bit 10 tone queue fault, read clears
// - bit 9 second rx queue fault, read clears
// - bit 8 first rx queue fault, read clears
// - bit 7 transmit level at/below limit, level
// - bit 6 tone queue above limit, level
// - bit 5 second rx queue above limit, level
// - bit 4 first rx queue above limit, level
// - bit 3 transmit done or error, read clears
// - bit 2 second rx packet ready, burst only
// - bit 1 first rx packet ready, burst only
// - bit 0 timer adjust done, read clears
// - write-only enable mask, reset clear, no side-effect
`ifndef BIF_DEFINES_VH
`define BIF_DEFINES_VH
`define BIF_ADDR_STATUS 8'h80
`define BIF_ADDR_ENABLE 8'h81
`define BIF_STATUS_RESET 16'h0080
`define BIF_ENABLE_RESET 16'h0000
`define BIF_LEVEL_MASK 16'h00f0
`define BIF_BIT_TX_LOW 7
`define BIF_BIT_TONE_HIGH 6
`define BIF_BIT_RX2_HIGH 5
`define BIF_BIT_RX1_HIGH 4
`define BIF_BURST_MASK 16'h3006
`endif

// ---- verilog/bif_sticky.v ----
// one clear-on-read sticky flag
`timescale 1ns/10ps
`default_nettype none
module bif_sticky (
    input wire clk_sys_in,    // system clock
    input wire rst_n_in,      // sync reset, active low
    input wire set_in,        // event pulse or level
    input wire clear_in,      // read of the status register
    output reg flag_out       // sticky flag
);
    // set has priority so an event during the read survives
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/bif_top.v ----
// interrupt flag collector with status, enable mask and irq pin
`timescale 1ns/10ps
`default_nettype none
`include "bif_defines.vh"
module bif_top (
    input wire clk_sys_in,             // 25 mhz system clock
    input wire rst_n_in,               // sync reset, active low
    input wire [7:0] reg_addr_in,      // register address
    input wire reg_wr_in,              // one-cycle write strobe
    input wire reg_rd_in,              // one-cycle read strobe
    input wire [15:0] reg_wdata_in,    // write data
    output reg [15:0] reg_rdata_out,   // read data, valid cycle after read
    input wire burst_mode_in,          // receive channels in burst mode
    input wire spcl_cmd_done_in,       // special command finished pulse
    input wire aux_conv_done_in,       // auxiliary converter sequence done pulse
    input wire second_rx_msg_end_in,   // second rx message end pulse
    input wire first_rx_msg_end_in,    // first rx message end pulse
    input wire tx_queue_fault_in,      // transmit fifo over/underflow pulse
    input wire tone_queue_fault_in,    // tone fifo over/underflow pulse
    input wire second_rx_queue_fault_in, // second rx fifo fault pulse
    input wire first_rx_queue_fault_in,  // first rx fifo fault pulse
    input wire [5:0] tx_fill_in,       // transmit fill level
    input wire [4:0] tx_fill_limit_in, // transmit threshold
    input wire [5:0] tone_fill_in,     // tone fill level
    input wire [4:0] tone_fill_limit_in, // tone threshold
    input wire [5:0] second_rx_fill_in,  // second rx fill level
    input wire [4:0] second_rx_fill_limit_in, // second rx threshold
    input wire [5:0] first_rx_fill_in, // first rx fill level
    input wire [4:0] first_rx_fill_limit_in, // first rx threshold
    input wire tx_done_in,             // transmit done or error pulse
    input wire second_rx_packet_ready_in, // second rx packet pulse
    input wire first_rx_packet_ready_in,  // first rx packet pulse
    input wire timer_adjust_done_in,   // slot/sample adjust done pulse
    output reg irq_out_n_out,          // open-drain pin level, always 0
    output reg irq_oe_out              // high while pulling pin low
);
    reg [15:0] enable_mask;     // write-only enable mask
    reg [3:0] level_flags;      // registered threshold levels
    wire [15:0] sticky_flags;   // clear-on-read flags
    wire [15:0] event_vec;      // raw event inputs
    wire [15:0] gated_events;   // events after burst-mode gating
    wire [15:0] status;         // composed status word
    wire status_read;           // host reads status this cycle
    wire [15:0] next_rdata;     // read mux result

    // gather the pulse sources into their bit positions
    assign event_vec = {spcl_cmd_done_in, aux_conv_done_in,
        second_rx_msg_end_in, first_rx_msg_end_in,
        tx_queue_fault_in, tone_queue_fault_in,
        second_rx_queue_fault_in, first_rx_queue_fault_in,
        4'h0, tx_done_in, second_rx_packet_ready_in,
        first_rx_packet_ready_in, timer_adjust_done_in};

    // burst-only sources are blocked outside burst mode
    assign gated_events = event_vec & (burst_mode_in ? 16'hffff : ~`BIF_BURST_MASK);

    assign status_read = reg_rd_in && (reg_addr_in == `BIF_ADDR_STATUS);

    // one sticky cell per clear-on-read bit; level bits get none
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_flag
            if (((`BIF_LEVEL_MASK >> i) & 16'h0001) == 16'h0000) begin : g_st
                bif_sticky u_flag (
                    .clk_sys_in(clk_sys_in),
                    .rst_n_in(rst_n_in),
                    .set_in(gated_events[i]),
                    .clear_in(status_read),
                    .flag_out(sticky_flags[i])
                );
            end else begin : g_lv
                assign sticky_flags[i] = 1'b0;
            end
        end
    endgenerate

    // threshold comparisons, registered; reset gives tx bit high
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            level_flags <= 4'h8;
        end else begin
            level_flags[3] <= ({1'b0, tx_fill_limit_in} >= tx_fill_in);
            level_flags[2] <= (tone_fill_in > {1'b0, tone_fill_limit_in});
            level_flags[1] <= (second_rx_fill_in > {1'b0, second_rx_fill_limit_in});
            level_flags[0] <= (first_rx_fill_in > {1'b0, first_rx_fill_limit_in});
        end
    end

    // compose status; level bits are never touched by a read
    assign status = sticky_flags | {8'h00, level_flags, 4'h0};

    // mask register; writing it leaves status untouched
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            enable_mask <= `BIF_ENABLE_RESET;
        end else if (reg_wr_in && (reg_addr_in == `BIF_ADDR_ENABLE)) begin
            enable_mask <= reg_wdata_in;
        end
    end

    // only status is readable; mask is write-only, others read zero
    assign next_rdata = status_read ? status : 16'h0000;

    // read data register, captured on the read strobe
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // pin pulled low while any enabled flag is set; reg adds one cycle
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_oe_out <= 1'b0;
            irq_out_n_out <= 1'b0;
        end else begin
            irq_oe_out <= |(status & enable_mask);
            irq_out_n_out <= 1'b0; // open-drain: only ever drives low
        end
    end
endmodule
`default_nettype wire

// ---- testbench/bif_chk_assertions.sv ----
// port checker for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module bif_chk (
    input wire clk_sys_in, // clock
    input wire rst_n_in, // sync reset
    input wire [7:0] reg_addr_in, // address
    input wire reg_rd_in, // read strobe
    input wire reg_wr_in, // write strobe
    input wire [15:0] reg_wdata_in, // write data
    input wire [15:0] reg_rdata_out, // read data
    input wire burst_mode_in, // burst gate
    input wire spcl_cmd_done_in, // bit 15 cause
    input wire first_rx_packet_ready_in, // bit 1 cause
    input wire [5:0] tx_fill_in, // tx level
    input wire [4:0] tx_fill_limit_in, // tx limit
    input wire irq_oe_out // pin pulled low
);
    wire rd80 = reg_rd_in && reg_addr_in == 8'h80; // status read
    wire wr81 = reg_wr_in && reg_addr_in == 8'h81; // mask write
    wire txlow = tx_fill_in <= {1'b0, tx_fill_limit_in}; // bit 7 cause
    wire pr = burst_mode_in && first_rx_packet_ready_in; // gated bit 1 cause
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_off_addr_zero: assert property (reg_rd_in && !rd80 |=> reg_rdata_out == 16'h0000) else $error("stray read not zero");
    a_cmd_clear: assert property (rd80 && !spcl_cmd_done_in ##1 !spcl_cmd_done_in ##1 rd80 |=> !reg_rdata_out[15]) else $error("bit 15 not cleared");
    a_set_wins: assert property (rd80 && spcl_cmd_done_in ##1 !rd80 ##1 rd80 |=> reg_rdata_out[15]) else $error("event lost in read");
    a_burst_gate: assert property (rd80 && !pr ##1 !pr ##1 rd80 |=> !reg_rdata_out[1]) else $error("bit 1 set outside burst");
    a_burst_set: assert property (pr ##1 !rd80 ##1 rd80 |=> reg_rdata_out[1]) else $error("bit 1 missing");
    a_tx_level: assert property (rd80 && $past(rst_n_in) |=> reg_rdata_out[7] == $past(txlow, 2)) else $error("bit 7 wrong");
    a_mask_off: assert property (wr81 && reg_wdata_in == 16'h0000 |-> ##2 !irq_oe_out) else $error("pin held with mask clear");
    a_irq_raise: assert property (wr81 && reg_wdata_in[15] ##1 !reg_wr_in ##1 spcl_cmd_done_in && !reg_wr_in |=> ##1 irq_oe_out) else $error("pin not pulled");
    cover property (rd80 && spcl_cmd_done_in);
    cover property (irq_oe_out);
    cover property (pr);
endmodule
bind bif_top bif_chk i_bif_chk (.*);
`default_nettype wire

// ---- testbench/bif_host_pin.sv ----
// host side of the open-drain interrupt pin, pulled up when released
`timescale 1ns/10ps
`default_nettype none
module bif_host_pin (
    input wire irq_oe_in, // device pulls pin
    input wire irq_n_in, // driven level
    output wire pin_n_out // level the host sees
);
    assign pin_n_out = irq_oe_in ? irq_n_in : 1'b1;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module tb;
    reg clk_sys_in = 0, rst_n_in = 0, reg_rd_in = 0, reg_wr_in = 0, burst_mode_in = 0; // bus
    reg [7:0] reg_addr_in = 8'h00; // address
    reg [15:0] reg_wdata_in = 16'h0000, ev = 16'h0000; // data, events by status bit
    reg [5:0] tx_fill_in = 6'h00, tone_fill_in = 6'h00, second_rx_fill_in = 6'h00, first_rx_fill_in = 6'h00;
    reg [4:0] tx_fill_limit_in = 5'h00, tone_fill_limit_in = 5'h00, second_rx_fill_limit_in = 5'h00, first_rx_fill_limit_in = 5'h00;
    wire [15:0] reg_rdata_out; // read data
    wire irq_out_n_out, irq_oe_out, pin_n; // pin pieces
    integer num_errors = 0, checked = 0, i, n;
    bif_top i_bif_top (.*, .spcl_cmd_done_in(ev[15]), .aux_conv_done_in(ev[14]), .second_rx_msg_end_in(ev[13]), .first_rx_msg_end_in(ev[12]), .tx_queue_fault_in(ev[11]), .tone_queue_fault_in(ev[10]), .second_rx_queue_fault_in(ev[9]), .first_rx_queue_fault_in(ev[8]), .tx_done_in(ev[3]), .second_rx_packet_ready_in(ev[2]), .first_rx_packet_ready_in(ev[1]), .timer_adjust_done_in(ev[0]));
    bif_host_pin i_bif_host_pin (.irq_oe_in(irq_oe_out), .irq_n_in(irq_out_n_out), .pin_n_out(pin_n));
    initial forever #20 clk_sys_in = !clk_sys_in;
    task chk(input string nm, input [15:0] s, e);
        checked = checked + 1;
        if (s !== e) begin num_errors = num_errors + 1; $display("BAD %s exp %h got %h", nm, e, s); end
    endtask
    // one strobe cycle; events in m ride along so a read can meet an event
    task rw(input w, input [7:0] a, input [15:0] d, m);
        @(negedge clk_sys_in); reg_addr_in = a; reg_wr_in = w; reg_rd_in = !w; reg_wdata_in = d; ev = m;
        @(negedge clk_sys_in); reg_wr_in = 0; reg_rd_in = 0; ev = 16'h0000;
    endtask
    task rdc(input [7:0] a, input [15:0] e, m);
        rw(0, a, 16'h0000, m);
        chk("rdata", reg_rdata_out, e);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_sys_in);
        rst_n_in = 1;
        rdc(8'h80, 16'h0080, 16'h0000);
        rdc(8'h81, 16'h0000, 16'h0000);
        $display("test reset done");
        burst_mode_in = 1;
        for (i = 0; i < 16; i = i + 1) if (i < 4 || i > 7) begin
            rdc(8'h00, 16'h0000, 16'h0001 << i);
            rdc(8'h80, 16'h0080 | (16'h0001 << i), 16'h0000);
            rdc(8'h80, 16'h0080, 16'h0000);
        end
        burst_mode_in = 0;
        rdc(8'h00, 16'h0000, 16'h3006);
        rdc(8'h80, 16'h0080, 16'h0000);
        $display("test events done");
        tx_fill_in = 6'h09; tx_fill_limit_in = 5'h08; tone_fill_in = 6'h09; tone_fill_limit_in = 5'h08;
        second_rx_fill_in = 6'h20; second_rx_fill_limit_in = 5'h1f; first_rx_fill_in = 6'h05; first_rx_fill_limit_in = 5'h05;
        rdc(8'h80, 16'h0060, 16'h8000);
        rdc(8'h80, 16'h8060, 16'h0000);
        rdc(8'h80, 16'h0060, 16'h0000);
        tx_fill_in = 6'h08; first_rx_fill_in = 6'h06; // tx at limit, first rx just above
        rdc(8'h80, 16'h00f0, 16'h0000);
        tx_fill_in = 6'h09; first_rx_fill_in = 6'h05; // back to the earlier levels
        rdc(8'h80, 16'h0060, 16'h0000);
        $display("test levels done");
        rw(1, 8'h81, 16'h8000, 16'h0000);
        chk("pin", pin_n, 16'h0001);
        rdc(8'h00, 16'h0000, 16'h8000);
        for (n = 0; n < 8 && pin_n; n = n + 1) @(negedge clk_sys_in);
        chk("pin", pin_n, 16'h0000);
        if (pin_n) final_report;
        rdc(8'h80, 16'h8060, 16'h0000);
        @(negedge clk_sys_in);
        chk("pin", pin_n, 16'h0001);
        rw(1, 8'h81, 16'h0040, 16'h0000);
        @(negedge clk_sys_in);
        chk("pin", pin_n, 16'h0000);
        rw(1, 8'h81, 16'h0000, 16'h0000);
        @(negedge clk_sys_in);
        chk("pin", pin_n, 16'h0001);
        $display("test pin done");
        final_report;
    end
endmodule
`default_nettype wire
